// *** rtl/pci_config_regs.sv ***
// configuration, compare and flag registers of the change interrupt port
`timescale 1ns/10ps
module pci_config_regs
  import pci_pkg::*;
#(
  parameter int PW          = PORT_W, // port width
  parameter bit SPI_VARIANT = 1'b1    // spi variant gates address pins
) (
  input  wire logic          core_clk,         // device clock
  input  wire logic          rst,              // async reset, high
  // register access port from the serial engine
  input  wire logic [7:0]    reg_addr,         // register pointer
  input  wire logic          reg_wr_en,        // write strobe
  input  wire logic [7:0]    reg_wr_data,      // write byte
  input  wire logic          reg_rd_en,        // read strobe
  output logic      [7:0]    reg_rd_data,      // read byte, next cycle
  // port state from surrounding registers
  input  wire logic [PW-1:0] pin_levels,       // sampled pin levels
  input  wire logic [PW-1:0] pin_is_input,     // direction, 1 = input
  input  wire logic [PW-1:0] change_irq_enables, // per-pin arm bits
  input  wire logic          irq_clear,        // capture or port read
  // capture path
  output logic               irq_capture,      // first-event pulse
  output logic      [PW-1:0] irq_captured_levels, // port at first event
  // configuration outputs
  output logic               auto_increment_off, // pointer held
  output logic               slew_limit_off,   // slew limiting off
  output logic               hw_address_pins_on, // address pins used
  output logic      [PW-1:0] pull_up_active,   // pull-up enables
  // address matching
  input  wire logic [1:0]    hw_address_pins,  // strapped pins
  input  wire logic [1:0]    ctrl_addr_bits,   // control byte bits
  output logic               addr_match,       // address hit
  // interrupt pin
  output logic               irq_pin_out,      // pin level
  output logic               irq_pin_oe_n      // low while driven
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [PW-1:0]  reference_levels;      // reference compare values
  logic [PW-1:0]  compare_source_select; // 1 = reference, 0 = previous
  logic [7:0]     device_config;         // stored config bits
  logic [PW-1:0]  pull_up_enables;       // pull-up bits
  logic [PW-1:0]  irq_flags;             // per-pin flags
  logic [PW-1:0]  prev_levels;           // last sampled levels
  pci_irq_state_t irq_state;             // pending or idle

  // per-pin decode
  logic [PW-1:0]  armed;                 // enabled input pins
  logic [PW-1:0]  pin_event;             // condition this cycle
  logic           any_event;             // some pin has condition
  logic           open_drain;            // config open-drain bit
  logic           pol_high;              // config polarity bit

  // address decode, reused for read and write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------

  // reference levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reference_levels <= PW'(RST_BYTE);
    end else if (reg_wr_en && hit(reg_addr, OFF_REFERENCE)) begin
      reference_levels <= reg_wr_data[PW-1:0];
    end
  end

  // compare source selection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compare_source_select <= PW'(RST_BYTE);
    end else if (reg_wr_en && hit(reg_addr, OFF_CMP_SEL)) begin
      compare_source_select <= reg_wr_data[PW-1:0];
    end
  end

  // device configuration; unimplemented bits never stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      device_config <= RST_BYTE;
    end else if (reg_wr_en && hit(reg_addr, OFF_CONFIG)) begin
      device_config <= reg_wr_data & CFG_WRITE_MASK;
    end
  end

  // pull-up enables
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pull_up_enables <= PW'(RST_BYTE);
    end else if (reg_wr_en && hit(reg_addr, OFF_PULL_UP)) begin
      pull_up_enables <= reg_wr_data[PW-1:0];
    end
  end
  // writes to the flag offset match no process above and are dropped

  // ---------------------------------------------------------------
  // configuration outputs, straight from the stored bits
  // ---------------------------------------------------------------
  assign auto_increment_off = device_config[CFG_AUTO_INC_OFF];
  assign slew_limit_off     = device_config[CFG_SLEW_OFF];
  assign hw_address_pins_on = device_config[CFG_HW_ADDR_ON];
  assign open_drain         = device_config[CFG_OPEN_DRAIN];
  assign pol_high           = device_config[CFG_POL_HIGH];

  // pull-up applies only to inputs; registered to keep outputs flopped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pull_up_active <= PW'(RST_BYTE);
    end else begin
      pull_up_active <= pull_up_enables & pin_is_input;
    end
  end

  // ---------------------------------------------------------------
  // change detection
  // ---------------------------------------------------------------

  // a pin is armed only when enabled and configured as input
  assign armed = change_irq_enables & pin_is_input;

  // per-pin compare against the selected source
  for (genvar i = 0; i < PW; i++) begin : g_pin
    always_comb begin
      if (!armed[i]) begin
        pin_event[i] = 1'b0; // disabled pins stay quiet
      end else if (compare_source_select[i]) begin
        // level compare, holds while mismatch persists
        pin_event[i] = pin_levels[i] != reference_levels[i];
      end else begin
        // edge compare against the last sample
        pin_event[i] = pin_levels[i] != prev_levels[i];
      end
    end
  end

  assign any_event = |pin_event;

  // previous levels follow the pin every cycle, so once a change has
  // raised its flag the new level is the base for the next change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_levels <= PW'(RST_BYTE);
    end else begin
      prev_levels <= pin_levels;
    end
  end

  // ---------------------------------------------------------------
  // flags: set wins over the clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_flags <= PW'(RST_BYTE);
    end else if (irq_clear) begin
      irq_flags <= pin_event; // new conditions survive the clear
    end else begin
      irq_flags <= irq_flags | pin_event; // later pins add flags
    end
  end

  // ---------------------------------------------------------------
  // pending state and capture
  // ---------------------------------------------------------------

  // interrupt held until a capture or port read; writes do not clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_state <= IRQ_IDLE;
    end else begin
      case (irq_state)
        IRQ_IDLE: begin
          if (any_event) begin
            irq_state <= IRQ_PENDING;
          end
        end
        IRQ_PENDING: begin
          if (irq_clear && !any_event) begin
            irq_state <= IRQ_IDLE;
          end
        end
        default: begin
          irq_state <= IRQ_IDLE;
        end
      endcase
    end
  end

  // only an event while idle or in a clear cycle captures the port; other events
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_capture         <= 1'b0;
      irq_captured_levels <= PW'(RST_BYTE);
    end else if (any_event && (irq_state == IRQ_IDLE || irq_clear)) begin
      irq_capture         <= 1'b1;
      irq_captured_levels <= pin_levels;
    end else begin
      irq_capture         <= 1'b0; // hold captured value
    end
  end

  // ---------------------------------------------------------------
  // read path: one cycle latency, unmapped offsets read zero
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= RST_BYTE;
    end else if (reg_rd_en) begin
      if (hit(reg_addr, OFF_REFERENCE)) begin
        reg_rd_data <= 8'(reference_levels);
      end else if (hit(reg_addr, OFF_CMP_SEL)) begin
        reg_rd_data <= 8'(compare_source_select);
      end else if (hit(reg_addr, OFF_CONFIG)) begin
        reg_rd_data <= device_config & CFG_WRITE_MASK;
      end else if (hit(reg_addr, OFF_PULL_UP)) begin
        reg_rd_data <= 8'(pull_up_enables);
      end else if (hit(reg_addr, OFF_IRQ_FLAGS)) begin
        reg_rd_data <= 8'(irq_flags);
      end else begin
        reg_rd_data <= RST_BYTE; // other offsets live elsewhere
      end
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  pci_addr_match #(
    .SPI_VARIANT(SPI_VARIANT)
  ) u_addr_match (
    .core_clk       (core_clk),
    .rst            (rst),
    .hw_address_pins(hw_address_pins),
    .ctrl_addr_bits (ctrl_addr_bits),
    .hw_addr_on     (hw_address_pins_on),
    .addr_match     (addr_match)
  );

  // interrupt pin follows the pending state
  pci_irq_pin u_irq_pin (
    .core_clk    (core_clk),
    .rst         (rst),
    .irq_active  (irq_state == IRQ_PENDING),
    .open_drain  (open_drain),
    .pol_high    (pol_high),
    .irq_pin_out (irq_pin_out),
    .irq_pin_oe_n(irq_pin_oe_n)
  );

endmodule // pci_config_regs

// *** include/pci_pkg.sv ***
// shared constants for the port change interrupt configuration block
package pci_pkg;
  localparam int PORT_W = 8;

  // register offsets
  localparam logic [7:0] OFF_REFERENCE = 8'h03;
  localparam logic [7:0] OFF_CMP_SEL   = 8'h04;
  localparam logic [7:0] OFF_CONFIG    = 8'h05;
  localparam logic [7:0] OFF_PULL_UP   = 8'h06;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h07;

  // configuration field positions
  localparam int CFG_AUTO_INC_OFF = 5;
  localparam int CFG_SLEW_OFF     = 4;
  localparam int CFG_HW_ADDR_ON   = 3;
  localparam int CFG_OPEN_DRAIN   = 2;
  localparam int CFG_POL_HIGH     = 1;

  // only bits 5..1 are stored
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3E;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_ADDR = 2'h0;

  // interrupt pending state
  typedef enum logic [0:0] {
    IRQ_IDLE    = 1'b0,
    IRQ_PENDING = 1'b1
  } pci_irq_state_t;
endpackage

// *** rtl/pci_addr_match.sv ***
// hardware address comparison for the serial control byte
`timescale 1ns/10ps
module pci_addr_match
  import pci_pkg::*;
#(
  parameter bit SPI_VARIANT = 1'b1 // 1: address pins gated by config
) (
  input  wire logic       core_clk,        // device clock
  input  wire logic       rst,             // async reset, high
  input  wire logic [1:0] hw_address_pins, // strapped address pins
  input  wire logic [1:0] ctrl_addr_bits,  // address bits of control byte
  input  wire logic       hw_addr_on,      // config enable of pins
  output logic            addr_match       // registered match result
);
  // i2c always compares; spi only when enabled, else every address hits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_match <= 1'b0;
    end else if (!SPI_VARIANT || hw_addr_on) begin
      addr_match <= (ctrl_addr_bits == hw_address_pins);
    end else begin
      addr_match <= 1'b1; // pins ignored
    end
  end
endmodule // pci_addr_match

// *** rtl/pci_irq_pin.sv ***
// interrupt pin driver: push-pull with polarity, or open-drain
`timescale 1ns/10ps
module pci_irq_pin (
  input  wire logic core_clk,    // device clock
  input  wire logic rst,         // async reset, high
  input  wire logic irq_active,  // interrupt pending
  input  wire logic open_drain,  // open-drain mode
  input  wire logic pol_high,    // active-high when driven
  output logic      irq_pin_out, // pin output level
  output logic      irq_pin_oe_n // low while pin driven
);
  // reset state matches config zero: driven, active-low, idle high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_pin_out  <= 1'b1;
      irq_pin_oe_n <= 1'b0;
    end else if (open_drain) begin
      // polarity ignored; only ever pull low
      irq_pin_out  <= 1'b0;
      irq_pin_oe_n <= !irq_active; // release when idle
    end else begin
      irq_pin_out  <= irq_active ? pol_high : !pol_high;
      irq_pin_oe_n <= 1'b0; // always driven
    end
  end
endmodule // pci_irq_pin

// *** verification/pci_host_model.sv ***
// host side model: register strobes and the clearing read of the capture
`timescale 1ns/10ps
module pci_host_model (
  input  wire logic       core_clk,    // device clock
  output logic      [7:0] reg_addr,    // register pointer
  output logic            reg_wr_en,   // write strobe
  output logic      [7:0] reg_wr_data, // write byte
  output logic            reg_rd_en,   // read strobe
  output logic            irq_clear,   // capture or port read
  input  wire logic [7:0] reg_rd_data  // read byte
);
  initial {reg_addr, reg_wr_en, reg_wr_data, reg_rd_en, irq_clear} = '0;

  // one byte per strobe; an idle cycle follows so strobes never merge
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge core_clk) #1;
    reg_wr_en = 1'b0;
    reg_wr_data = ~d; // released data must not look like the last byte
    @(posedge core_clk) #1;
  endtask

  // read byte is taken the cycle after the strobe edge, where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge core_clk) #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    @(posedge core_clk) d = reg_rd_data;
    #1;
  endtask

  // a read of capture or port register releases the interrupt
  task automatic clr();
    irq_clear = 1'b1;
    @(posedge core_clk) #1;
    irq_clear = 1'b0;
    @(posedge core_clk) #1;
  endtask
endmodule // pci_host_model

// *** verification/pci_chk_properties.sv ***
// port-level checks of the change interrupt configuration block
`timescale 1ns/10ps
module pci_chk (
  input wire logic       core_clk,            // device clock
  input wire logic       rst,                 // async reset, high
  input wire logic       reg_wr_en,           // write strobe
  input wire logic       reg_rd_en,           // read strobe
  input wire logic       irq_clear,           // capture or port read
  input wire logic       irq_capture,         // capture pulse
  input wire logic       auto_increment_off,  // config bit 5
  input wire logic       slew_limit_off,      // config bit 4
  input wire logic       irq_pin_out,         // interrupt pin level
  input wire logic       irq_pin_oe_n,        // low while pin driven
  input wire logic [7:0] reg_addr,            // register pointer
  input wire logic [7:0] reg_wr_data,         // write byte
  input wire logic [7:0] reg_rd_data,         // read byte
  input wire logic [7:0] pin_levels,          // sampled pin levels
  input wire logic [7:0] pin_is_input,        // direction, 1 = input
  input wire logic [7:0] change_irq_enables,  // per-pin arm bits
  input wire logic [7:0] irq_captured_levels, // levels at first event
  input wire logic [7:0] pull_up_active       // pull-up enables out
);
  logic [7:0] cfg_seen; // config byte as last written by the host

  // shadow of the config byte, built from host writes alone so the pin
  // check does not lean on the design's own copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_seen <= 8'h00;
    end else if (reg_wr_en && reg_addr == 8'h05) begin
      cfg_seen <= reg_wr_data;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_cfg_seq_bit: assert property (
    reg_wr_en && reg_addr == 8'h05 |=> auto_increment_off == $past(reg_wr_data[5]))
    else $error("pointer hold bit not taken from write");
  a_cfg_slew_bit: assert property (
    reg_wr_en && reg_addr == 8'h05 |=> slew_limit_off == $past(reg_wr_data[4]))
    else $error("slew bit not taken from write");
  a_cfg_unused_zero: assert property (
    reg_rd_en && reg_addr == 8'h05 |=> (reg_rd_data & 8'hC1) == 8'h00)
    else $error("unused config bits read nonzero");
  // an output pin must never see its pull-up
  a_pullup_gated: assert property (
    (pull_up_active & ~$past(pin_is_input)) == 8'h00)
    else $error("pull-up on an output pin");
  a_capture_armed: assert property (
    irq_capture |-> ($past(change_irq_enables) & $past(pin_is_input)) != 8'h00)
    else $error("capture with no armed input");
  a_capture_value: assert property (
    irq_capture |-> irq_captured_levels == $past(pin_levels))
    else $error("captured levels wrong");
  // a capture not met by a clear must not repeat in the next cycle
  a_capture_single: assert property (
    irq_capture && !irq_clear |=> !irq_capture)
    else $error("second capture while pending");
  a_capture_hold: assert property (
    !irq_capture |-> $stable(irq_captured_levels))
    else $error("captured levels moved without capture");
  // active pin: open-drain pulls low, otherwise the polarity bit decides
  a_pin_follows: assert property (
    irq_capture |=> !irq_pin_oe_n &&
      irq_pin_out == ($past(cfg_seen[2]) ? 1'b0 : $past(cfg_seen[1])))
    else $error("interrupt pin not at its active level");
endmodule // pci_chk

bind pci_config_regs pci_chk u_chk (.core_clk, .rst, .reg_wr_en, .reg_rd_en, .irq_clear,
  .irq_capture, .auto_increment_off, .slew_limit_off, .irq_pin_out, .irq_pin_oe_n, .reg_addr,
  .reg_wr_data, .reg_rd_data, .pin_levels, .pin_is_input, .change_irq_enables,
  .irq_captured_levels, .pull_up_active);

// *** verification/pci_config_regs_tb.sv ***
// self-checking bench for the change interrupt configuration block
`timescale 1ns/10ps
module pci_config_regs_tb;
  logic       core_clk, rst, irq_clear, reg_wr_en, reg_rd_en, act;
  logic       irq_capture, auto_increment_off, slew_limit_off, hw_address_pins_on;
  logic       addr_match, irq_pin_out, irq_pin_oe_n, irq_wire;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, pin_levels, pin_is_input;
  logic [7:0] change_irq_enables, irq_captured_levels, pull_up_active, a8, d, p, c;
  logic [1:0] hw_address_pins, ctrl_addr_bits;
  int         err_count, total_checks;

  // board pull-up: a released line reads high
  assign irq_wire = irq_pin_oe_n ? 1'b1 : irq_pin_out;

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  pci_config_regs uut (.core_clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .reg_rd_data, .pin_levels, .pin_is_input, .change_irq_enables, .irq_clear,
    .irq_capture, .irq_captured_levels, .auto_increment_off, .slew_limit_off,
    .hw_address_pins_on, .pull_up_active, .hw_address_pins, .ctrl_addr_bits,
    .addr_match, .irq_pin_out, .irq_pin_oe_n);
  pci_host_model host (.core_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .irq_clear, .reg_rd_data);

  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, e);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, e);
  endtask

  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // config keeps only bits 5..1
  function automatic logic [7:0] exp_rd(logic [7:0] a, v);
    return (a == 8'h05) ? (v & 8'h3E) : v;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    complete_run();
  end

  initial begin
    {rst, pin_levels, pin_is_input, change_irq_enables} = {1'b1, 24'h0};
    {hw_address_pins, ctrl_addr_bits} = 4'h0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(32'h2430CF65));
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int i = 3; i < 8; i++) rdc(8'(i), 8'h00);
    rdc(8'h0B, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      a8 = 8'(3 + i % 4);
      d = 8'($urandom);
      host.wr(a8, d);
      rdc(a8, exp_rd(a8, d));
      if (a8 == 8'h05) begin
        chk(8'({auto_increment_off, slew_limit_off, hw_address_pins_on}), 8'(d[5:3]));
      end
    end
    host.wr(8'h07, 8'hFF);
    rdc(8'h07, 8'h00);
    d = 8'($urandom);
    p = 8'($urandom);
    host.wr(8'h06, d);
    pin_is_input = p;
    cyc(2);
    chk(pull_up_active, d & p);
    for (int i = 0; i < 8; i++) begin
      {hw_address_pins, ctrl_addr_bits} = 4'($urandom);
      host.wr(8'h05, {4'h0, i[0], 3'h0});
      chk(8'(addr_match), 8'(!i[0] || hw_address_pins == ctrl_addr_bits));
    end
    $display("test registers done");
    // previous-value mode; pin 4 is an armed output
    pin_is_input = 8'hEF;
    host.wr(8'h04, 8'h00);
    change_irq_enables = 8'h13;
    pin_levels = 8'h10;
    cyc(3);
    host.clr();
    rdc(8'h07, 8'h00);
    pin_levels = 8'h11;
    cyc(1);
    chk(8'(irq_capture), 8'h01);
    cyc(2);
    rdc(8'h07, 8'h01);
    pin_levels = 8'h13;
    cyc(1);
    chk(8'(irq_capture), 8'h00);
    cyc(2);
    rdc(8'h07, 8'h03);
    chk(irq_captured_levels, 8'h11);
    host.clr();
    rdc(8'h07, 8'h00);
    pin_levels = 8'h1B;
    cyc(3);
    rdc(8'h07, 8'h00);
    $display("test previous mode done");
    // reference mode, pin driven open-drain, active-low, active-high
    host.wr(8'h03, 8'h13);
    host.wr(8'h04, 8'hFF);
    host.clr();
    for (int m = 0; m < 3; m++) begin
      c = (m == 0) ? 8'h04 : ((m == 1) ? 8'h00 : 8'h02);
      act = c[2] ? 1'b0 : c[1];
      host.wr(8'h05, c);
      cyc(2);
      chk(8'(irq_wire), 8'(!act));
      pin_levels = 8'h1A;
      cyc(4);
      chk(8'(irq_wire), 8'(act));
      host.clr();
      rdc(8'h07, 8'h01);
      pin_levels = 8'h1B;
      host.clr();
      cyc(3);
      chk(8'(irq_wire), 8'(!act));
    end
    $display("test reference mode done");
    // a reset in mid-run must wipe everything written above; arming is
    // dropped first so the zeroed previous levels raise no event
    change_irq_enables = 8'h00;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    for (int i = 3; i < 8; i++) rdc(8'(i), 8'h00);
    chk(irq_captured_levels, 8'h00);
    chk(8'(irq_wire), 8'h01);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // pci_config_regs_tb
